/* File: rtl/sfpp_pkg.sv */
/*
  Shared constants and types of the SPI flash programming port.
  Assumes a 20 MHz core clock on both ends of the link.
*/
package sfpp_pkg;
  // Command bytes
  localparam logic [7:0] WRITE_ENABLE_CMD        = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD       = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD         = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD        = 8'h01;
  localparam logic [7:0] READ_CMD                = 8'h03;
  localparam logic [7:0] PROGRAM_CMD             = 8'h02;
  localparam logic [7:0] ERASE_PAGE_CMD          = 8'h52;
  localparam logic [7:0] ERASE_ALL_CMD           = 8'h62;
  localparam logic [7:0] PROTECT_CONFIG_READ_CMD = 8'h89;
  localparam logic [7:0] INFO_READBACK_LOCK_CMD  = 8'h84;
  localparam logic [7:0] MAIN_READBACK_LOCK_CMD  = 8'h85;
  localparam logic [7:0] DEBUGGER_ENABLE_CMD     = 8'h86;
  // Flash status register bit positions
  localparam int ST_DEBUG_BIT     = 7;
  localparam int ST_WEN_BIT       = 5;
  localparam int ST_READY_LOW_BIT = 4;
  localparam int ST_INFO_SEL_BIT  = 3;
  localparam int ST_MAIN_LOCK_BIT = 2;
  localparam int ST_INFO_LOCK_BIT = 1;
  // Flash geometry
  localparam int MAIN_BYTES = 32768;
  localparam int MAIN_AW    = 15;
  localparam int INFO_BYTES = 512;
  localparam int INFO_AW    = 9;
  localparam int BUF_BYTES  = 256;
  localparam logic [15:0] PAGE_LAST = 16'h01ff;
  localparam logic [15:0] MAIN_LAST = 16'h7fff;
  localparam logic [8:0]  INFO_LOCK_ADDR  = 9'h022;
  localparam logic [8:0]  MAIN_LOCK_ADDR  = 9'h023;
  localparam logic [8:0]  DEBUG_MARK_ADDR = 9'h024;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CNT_W         = 20;
  localparam int PROGRAM_MODE_PIN_BYTE_CYC = 365;
  localparam int ERASE_CYC     = 360000;
  localparam int LOCK_CYC      = 730;
  localparam int PROGRAM_MODE_PIN_SETUP_NS = 1500000;
  localparam int PROGRAM_MODE_PIN_SETUP_CYC = (PROGRAM_MODE_PIN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCK_HALF_CYC = 4'h8;
  // Controller register map
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_XFER   = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam int CTRL_PROGRAM_MODE_PIN_BIT  = 0;
  localparam int CTRL_SEL_BIT   = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SETUP_BIT = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Frame phases of the device
  typedef enum logic [2:0] {
    PH_CMD     = 3'b000,
    PH_ADDR_HI = 3'b001,
    PH_ADDR_LO = 3'b010,
    PH_DATA    = 3'b011,
    PH_SKIP    = 3'b100
  } sfpp_phase_t;
  // Self timed flash operations
  typedef enum logic [2:0] {
    OP_IDLE       = 3'b000,
    OP_PROGRAM    = 3'b001,
    OP_ERASE_PAGE = 3'b010,
    OP_ERASE_ALL  = 3'b011,
    OP_INFO_LOCK  = 3'b100,
    OP_MAIN_LOCK  = 3'b101,
    OP_DEBUG      = 3'b110
  } sfpp_op_t;
  // Controller shift states
  typedef enum logic [0:0] {
    HS_IDLE  = 1'b0,
    HS_SHIFT = 1'b1
  } sfpp_hstate_t;
endpackage

/* File: rtl/sfpp_link_if.sv */
/*
  Pins between programmer and device.
  Assumes the bench resolves miso from miso_oe.
*/
`timescale 1ns/1ns
interface sfpp_link_if;
  logic program_mode_pin;
  logic sck;
  logic chip_select_low;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev  (input program_mode_pin, sck, chip_select_low, mosi, output miso, miso_oe);
  modport host (output program_mode_pin, sck, chip_select_low, mosi, input miso, miso_oe);
endinterface // sfpp_link_if

/* File: rtl/sfpp_dev.sv */
/*
  Device end: SPI slave serving flash commands, flash arrays and the
  self timed program and erase engine.
  Assumes the link pins are asynchronous to CORE_CLK and that the link
  clock is slow enough for two flop synchronisers (half period >= 8).
*/
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
// Function
// (R1) Programmer holds program pin, waits 1.5 ms
// (R2) Program pin turns pins into SPI slave
// (R3) Write enable clear at reset, after operations
// (R4) Programmer sends write enable before each operation
// (R5) Info select bit picks region each access
// (R6) Command byte first, bytes MSB first
// (R7) 0x06 sets, 0x04 clears write enable
// (R8) 0x05 streams status while selected
// (R9) 0x01 writes only bits 5 and 3
// (R10) 0x03 streams data, auto increment, wraps
// (R11) Locked regions read back as zero
// (R12) 0x02 programs 1-256 bytes from address
// (R13) 0x52 erases one page in region
// (R14) 0x62 erases whole main array
// (R15) 0x89 returns protection configuration byte
// (R16) 0x84 locks info page, marks 0x22
// (R17) 0x85 locks main array, marks 0x23
// (R18) 0x86 marks 0x24, debugger after reset
// (R19) Programmer waits or polls ready before next
// (R20) Status bit layout 5,4,3,2,1
// (R21) Program takes (n+1)*365, only status read
// (R22) Erase takes 360000, only status read
// (R23) Unknown commands ignored until deselect
module sfpp_dev
  import sfpp_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  // Link to the programmer
  sfpp_link_if.dev        LINK,
  // Device side
  input  wire logic [7:0] PROTECT_CONFIG,
  output logic            SPI_SLAVE_SEL,
  output logic            FLASH_BUSY,
  output logic            DEBUGGER_EN
);
  logic [2:0]  sck_sy, csn_sy;
  logic [1:0]  program_mode_pin_sy, mosi_sy;
  logic [2:0]  bit_ff;
  logic [6:0]  rx_ff;
  logic [7:0]  tx_ff, opc_ff, page_ff, status, rd_data, wr_data, old_data;
  logic [15:0] addr_ff, rd_addr, wa;
  logic [8:0]  pcnt_ff;
  logic        miso_ff, oe_ff, wen_ff, info_page_select_bit_ff, done_ff, init_ff;
  logic        busy_ff, walking_ff, sel_ff, info_readback_lock_cmd_ff, main_readback_lock_cmd_ff, dbg_ff;
  logic        we_main, we_info;
  logic [15:0] walk_ff, walk_end_ff, base_ff;
  logic [CNT_W-1:0] cnt_ff;
  sfpp_phase_t phase_ff;
  sfpp_op_t    pend_ff, op_ff;
  logic [7:0]  main_mem [MAIN_BYTES];
  logic [7:0]  info_mem [INFO_BYTES];
  logic [7:0]  pbuf     [BUF_BYTES];

  wire frame     = program_mode_pin_sy[1] & ~csn_sy[1];
  wire frame_end = csn_sy[1] & ~csn_sy[2];
  wire sck_rise  = sck_sy[1] & ~sck_sy[2];
  wire sck_fall  = ~sck_sy[1] & sck_sy[2];
  wire [7:0] rx_byte = {rx_ff, mosi_sy[1]};
  wire byte_done = frame & sck_rise & (bit_ff == 3'h7);
  wire start     = frame_end & (pend_ff != OP_IDLE) & wen_ff & ~busy_ff; // R4

  // Link synchronisers
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      program_mode_pin_sy <= 2'h0;
      sck_sy  <= 3'h0;
      csn_sy  <= 3'h7;
      mosi_sy <= 2'h0;
    end else begin
      program_mode_pin_sy <= {program_mode_pin_sy[0], LINK.program_mode_pin};
      sck_sy  <= {sck_sy[1:0], LINK.sck};
      csn_sy  <= {csn_sy[1:0], LINK.chip_select_low};
      mosi_sy <= {mosi_sy[0], LINK.mosi};
    end
  end

  // Bit counter and receive shifter, MSB first
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || !frame) begin
      bit_ff <= 3'h0;
      rx_ff  <= 7'h00;
    end else if (sck_rise) begin
      bit_ff <= bit_ff + 3'h1;
      rx_ff  <= {rx_ff[5:0], mosi_sy[1]}; // R6
    end
  end

  // Status byte
  always_comb begin
    status = 8'h00;
    status[ST_DEBUG_BIT]     = dbg_ff;
    status[ST_WEN_BIT]       = wen_ff;    // R20
    status[ST_READY_LOW_BIT] = busy_ff;   // R20
    status[ST_INFO_SEL_BIT]  = info_page_select_bit_ff;  // R20
    status[ST_MAIN_LOCK_BIT] = main_readback_lock_cmd_ff; // R20
    status[ST_INFO_LOCK_BIT] = info_readback_lock_cmd_ff; // R20
  end

  // Read path with region select and read-back lock
  assign rd_addr = (phase_ff == PH_ADDR_LO) ? {addr_ff[15:8], rx_byte} : addr_ff;
  always_comb begin
    if (info_page_select_bit_ff) begin
      rd_data = info_readback_lock_cmd_ff ? 8'h00 : info_mem[rd_addr[INFO_AW-1:0]]; // R5 R11
    end else begin
      rd_data = main_readback_lock_cmd_ff ? 8'h00 : main_mem[rd_addr[MAIN_AW-1:0]]; // R5 R11
    end
  end

  // Command decoder and reply loader
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      phase_ff <= PH_CMD;
      opc_ff   <= 8'h00;
      addr_ff  <= 16'h0000;
      page_ff  <= 8'h00;
      pcnt_ff  <= 9'h000;
      pend_ff  <= OP_IDLE;
      tx_ff    <= 8'h00;
      wen_ff   <= 1'b0; // R3
      info_page_select_bit_ff <= 1'b0;
    end else begin
      if (done_ff) begin
        wen_ff <= 1'b0; // R3
      end
      if (!frame) begin
        phase_ff <= PH_CMD;
        pend_ff  <= OP_IDLE;
        pcnt_ff  <= 9'h000;
        tx_ff    <= 8'h00;
      end else if (sck_fall) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end else if (byte_done) begin
        case (phase_ff)
          PH_CMD: begin
            opc_ff   <= rx_byte;
            phase_ff <= PH_SKIP;
            tx_ff    <= 8'h00;
            if (!busy_ff || rx_byte == STATUS_READ_CMD) begin // R21 R22
              case (rx_byte)
                WRITE_ENABLE_CMD:        wen_ff <= 1'b1; // R7
                WRITE_DISABLE_CMD:       wen_ff <= 1'b0; // R7
                STATUS_READ_CMD: begin
                  tx_ff    <= status; // R8
                  phase_ff <= PH_DATA;
                end
                STATUS_WRITE_CMD:        phase_ff <= PH_DATA;
                READ_CMD, PROGRAM_CMD:   phase_ff <= PH_ADDR_HI;
                ERASE_PAGE_CMD:          phase_ff <= PH_DATA;
                ERASE_ALL_CMD:           pend_ff <= OP_ERASE_ALL; // R14
                PROTECT_CONFIG_READ_CMD: tx_ff <= PROTECT_CONFIG; // R15
                INFO_READBACK_LOCK_CMD:  pend_ff <= OP_INFO_LOCK; // R16
                MAIN_READBACK_LOCK_CMD:  pend_ff <= OP_MAIN_LOCK; // R17
                DEBUGGER_ENABLE_CMD:     pend_ff <= dbg_ff ? OP_IDLE : OP_DEBUG; // R18
                default:                 phase_ff <= PH_SKIP; // R23
              endcase
            end
          end
          PH_ADDR_HI: begin
            addr_ff[15:8] <= rx_byte;
            phase_ff      <= PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            phase_ff <= PH_DATA;
            if (opc_ff == READ_CMD) begin
              tx_ff   <= rd_data;
              addr_ff <= rd_addr + 16'h0001; // R10
            end else begin
              addr_ff[7:0] <= rx_byte;
            end
          end
          PH_DATA: begin
            case (opc_ff)
              STATUS_READ_CMD: tx_ff <= status; // R8
              STATUS_WRITE_CMD: begin
                wen_ff   <= rx_byte[ST_WEN_BIT];      // R9
                info_page_select_bit_ff <= rx_byte[ST_INFO_SEL_BIT]; // R9
                phase_ff <= PH_SKIP;
              end
              READ_CMD: begin
                tx_ff   <= rd_data;
                addr_ff <= addr_ff + 16'h0001; // R10
              end
              PROGRAM_CMD: begin
                if (pcnt_ff != 9'(BUF_BYTES)) begin
                  pbuf[pcnt_ff[7:0]] <= rx_byte; // R12
                  pcnt_ff            <= pcnt_ff + 9'h001;
                  pend_ff            <= OP_PROGRAM;
                end
              end
              ERASE_PAGE_CMD: begin
                page_ff  <= rx_byte;
                pend_ff  <= OP_ERASE_PAGE; // R13
                phase_ff <= PH_SKIP;
              end
              default: phase_ff <= PH_SKIP;
            endcase
          end
          default: phase_ff <= PH_SKIP;
        endcase
      end
    end
  end

  // MISO driven on falling link edges while selected
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      miso_ff <= 1'b0;
      oe_ff   <= 1'b0;
    end else begin
      oe_ff <= frame; // R2
      if (!frame) begin
        miso_ff <= 1'b0;
      end else if (sck_fall) begin
        miso_ff <= tx_ff[7]; // R6
      end
    end
  end

  // Self timed program and erase engine
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      op_ff       <= OP_IDLE;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      walking_ff  <= 1'b0;
      sel_ff      <= 1'b0;
      cnt_ff      <= '0;
      walk_ff     <= 16'h0000;
      walk_end_ff <= 16'h0000;
      base_ff     <= 16'h0000;
      init_ff     <= 1'b1;
      info_readback_lock_cmd_ff   <= 1'b0;
      main_readback_lock_cmd_ff   <= 1'b0;
      dbg_ff      <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (init_ff) begin
        init_ff   <= 1'b0;
        info_readback_lock_cmd_ff <= info_mem[INFO_LOCK_ADDR] != 8'hff;
        main_readback_lock_cmd_ff <= info_mem[MAIN_LOCK_ADDR] != 8'hff;
        dbg_ff    <= (info_mem[DEBUG_MARK_ADDR] != 8'hff) && (info_mem[MAIN_LOCK_ADDR] == 8'hff); // R18
      end else if (start) begin
        busy_ff     <= 1'b1;
        op_ff       <= pend_ff;
        walk_ff     <= 16'h0000;
        walking_ff  <= 1'b1;
        sel_ff      <= 1'b1;
        walk_end_ff <= 16'h0000;
        cnt_ff      <= CNT_W'(LOCK_CYC - 1);
        case (pend_ff)
          OP_PROGRAM: begin
            sel_ff      <= info_page_select_bit_ff; // R5
            walking_ff  <= ~main_readback_lock_cmd_ff;
            base_ff     <= addr_ff;
            walk_end_ff <= 16'(pcnt_ff) - 16'h0001;
            cnt_ff      <= (CNT_W'(pcnt_ff) + CNT_W'(1)) * CNT_W'(PROGRAM_MODE_PIN_BYTE_CYC) - CNT_W'(1); // R21
          end
          OP_ERASE_PAGE: begin
            sel_ff      <= info_page_select_bit_ff; // R5
            walking_ff  <= ~main_readback_lock_cmd_ff;
            base_ff     <= info_page_select_bit_ff ? 16'h0000 : {1'b0, page_ff[5:0], 9'h000};
            walk_end_ff <= PAGE_LAST;
            cnt_ff      <= CNT_W'(ERASE_CYCLES - 1); // R22
            if (info_page_select_bit_ff && !main_readback_lock_cmd_ff) begin
              info_readback_lock_cmd_ff <= 1'b0;
            end
          end
          OP_ERASE_ALL: begin
            sel_ff      <= 1'b0;
            base_ff     <= 16'h0000;
            walk_end_ff <= MAIN_LAST; // R14
            cnt_ff      <= CNT_W'(ERASE_CYCLES - 1);
            main_readback_lock_cmd_ff   <= 1'b0;
          end
          OP_INFO_LOCK: begin
            base_ff   <= 16'(INFO_LOCK_ADDR);
            info_readback_lock_cmd_ff <= 1'b1; // R16
          end
          OP_MAIN_LOCK: begin
            base_ff   <= 16'(MAIN_LOCK_ADDR);
            main_readback_lock_cmd_ff <= 1'b1; // R17
          end
          default: base_ff <= 16'(DEBUG_MARK_ADDR); // R18
        endcase
      end else if (busy_ff) begin
        if (walking_ff) begin
          walking_ff <= walk_ff != walk_end_ff;
          walk_ff    <= walk_ff + 16'h0001;
        end
        if (cnt_ff != '0) begin
          cnt_ff <= cnt_ff - CNT_W'(1);
        end else if (!walking_ff) begin
          busy_ff <= 1'b0;
          op_ff   <= OP_IDLE;
          done_ff <= 1'b1; // R3
        end
      end
    end
  end

  // Write port of the flash arrays; programming only clears bits
  assign wa       = base_ff + walk_ff;
  assign old_data = sel_ff ? info_mem[wa[INFO_AW-1:0]] : main_mem[wa[MAIN_AW-1:0]];
  always_comb begin
    case (op_ff)
      OP_PROGRAM:                  wr_data = old_data & pbuf[walk_ff[7:0]]; // R12
      OP_ERASE_PAGE, OP_ERASE_ALL: wr_data = 8'hff;
      default:                     wr_data = 8'h00;
    endcase
  end
  assign we_main = busy_ff & walking_ff & ~sel_ff;
  assign we_info = busy_ff & walking_ff & sel_ff;

  // Blank flash at power up
  initial begin
    for (int i = 0; i < MAIN_BYTES; i++) main_mem[i] = 8'hff;
    for (int i = 0; i < INFO_BYTES; i++) info_mem[i] = 8'hff;
  end

  // Flash array storage; plain always as the power-up fill also writes it
  always @(posedge CORE_CLK) begin
    if (we_main) begin
      main_mem[wa[MAIN_AW-1:0]] <= wr_data;
    end
    if (we_info) begin
      info_mem[wa[INFO_AW-1:0]] <= wr_data;
    end
  end

  assign LINK.miso     = miso_ff;
  assign LINK.miso_oe  = oe_ff;
  assign SPI_SLAVE_SEL = program_mode_pin_sy[1]; // R2
  assign FLASH_BUSY    = busy_ff;
  assign DEBUGGER_EN   = dbg_ff;
endmodule // sfpp_dev

/* File: rtl/sfpp_host.sv */
/*
  Programmer end: AXI4-Lite register slave driving the program pin,
  chip select and one SPI byte per write, link clock by divider.
  Assumes software sequences commands, write enables and ready polls.
*/
`timescale 1ns/1ns
module sfpp_host
  import sfpp_pkg::*;
#(
  parameter int SETUP_CYCLES = PROGRAM_MODE_PIN_SETUP_CYC
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // AXI4-Lite write
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Link to the device
  sfpp_link_if.host        LINK
);
  logic        aw_have, w_have, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff, awsel_ff;
  logic [31:0] wdata_ff, rdata_ff, rd_mux;
  logic        wstrb0_ff, program_mode_pin_ff, sel_ff, setup_ff, csn_ff, sck_ff, mosi_ff;
  logic [CNT_W-1:0] setup_cnt;
  logic [1:0]  miso_sy;
  logic [3:0]  div_ff, half_ff;
  logic [7:0]  sh_ff, rxsh_ff, rx_ff;
  sfpp_hstate_t hs_ff;

  wire wr_fire = aw_have & w_have & ~bvalid_ff;
  wire xfer_go = wr_fire & (awsel_ff == REG_XFER) & (hs_ff == HS_IDLE) & ~csn_ff;

  // Write address and data captured in either order
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      aw_have    <= 1'b0;
      w_have     <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      awsel_ff   <= 2'h0;
      wdata_ff   <= 32'h0;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      awready_ff <= ~aw_have & ~(awready_ff & S_AXI_AWVALID);
      wready_ff  <= ~w_have & ~(wready_ff & S_AXI_WVALID);
      if (awready_ff && S_AXI_AWVALID) begin
        aw_have  <= 1'b1;
        awsel_ff <= S_AXI_AWADDR[3:2];
      end else if (wr_fire) begin
        aw_have <= 1'b0;
      end
      if (wready_ff && S_AXI_WVALID) begin
        w_have    <= 1'b1;
        wdata_ff  <= S_AXI_WDATA;
        wstrb0_ff <= S_AXI_WSTRB[0];
      end else if (wr_fire) begin
        w_have <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awsel_ff == REG_CTRL || awsel_ff == REG_XFER) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      program_mode_pin_ff <= 1'b0;
      sel_ff  <= 1'b0;
    end else if (wr_fire && awsel_ff == REG_CTRL && wstrb0_ff) begin
      program_mode_pin_ff <= wdata_ff[CTRL_PROGRAM_MODE_PIN_BIT];
      sel_ff  <= wdata_ff[CTRL_SEL_BIT];
    end
  end

  // Program pin settling wait gates chip select
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || !program_mode_pin_ff) begin
      setup_cnt <= '0;
      setup_ff  <= 1'b0;
      csn_ff    <= 1'b1;
    end else begin
      if (setup_cnt == CNT_W'(SETUP_CYCLES - 1)) begin
        setup_ff <= 1'b1; // R1
      end else begin
        setup_cnt <= setup_cnt + CNT_W'(1);
      end
      if (hs_ff == HS_IDLE) begin
        csn_ff <= ~(sel_ff & setup_ff); // R1
      end
    end
  end

  // MISO synchroniser
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      miso_sy <= 2'h0;
    end else begin
      miso_sy <= {miso_sy[0], LINK.miso};
    end
  end

  // Byte shifter, mode 0, MSB first
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      hs_ff   <= HS_IDLE;
      div_ff  <= 4'h0;
      half_ff <= 4'h0;
      sck_ff  <= 1'b0;
      mosi_ff <= 1'b0;
      sh_ff   <= 8'h00;
      rxsh_ff <= 8'h00;
      rx_ff   <= 8'h00;
    end else begin
      case (hs_ff)
        HS_IDLE: begin
          if (xfer_go) begin
            hs_ff   <= HS_SHIFT;
            sh_ff   <= wdata_ff[7:0];
            mosi_ff <= wdata_ff[7]; // R6
            div_ff  <= 4'h0;
            half_ff <= 4'h0;
          end
        end
        HS_SHIFT: begin
          if (div_ff == SCK_HALF_CYC - 4'h1) begin
            div_ff  <= 4'h0;
            half_ff <= half_ff + 4'h1;
            if (!half_ff[0]) begin
              sck_ff  <= 1'b1;
              rxsh_ff <= {rxsh_ff[6:0], miso_sy[1]};
            end else begin
              sck_ff <= 1'b0;
              if (half_ff == 4'hf) begin
                hs_ff <= HS_IDLE;
                rx_ff <= rxsh_ff;
              end else begin
                mosi_ff <= sh_ff[6]; // R6
                sh_ff   <= {sh_ff[6:0], 1'b0};
              end
            end
          end else begin
            div_ff <= div_ff + 4'h1;
          end
        end
        default: hs_ff <= HS_IDLE;
      endcase
    end
  end

  // Read mux
  always_comb begin
    rd_mux = 32'h0;
    case (S_AXI_ARADDR[3:2])
      REG_CTRL: begin
        rd_mux[CTRL_PROGRAM_MODE_PIN_BIT] = program_mode_pin_ff;
        rd_mux[CTRL_SEL_BIT]  = sel_ff;
      end
      REG_XFER: rd_mux[7:0] = rx_ff;
      REG_STATUS: begin
        rd_mux[STAT_BUSY_BIT]  = hs_ff == HS_SHIFT;
        rd_mux[STAT_SETUP_BIT] = setup_ff;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // Read channel
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= ~rvalid_ff & ~(arready_ff & S_AXI_ARVALID);
      if (arready_ff && S_AXI_ARVALID) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= (S_AXI_ARADDR[3:2] == 2'h3) ? RESP_SLVERR : RESP_OKAY;
      end else if (S_AXI_RREADY) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY  = wready_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign LINK.program_mode_pin     = program_mode_pin_ff;
  assign LINK.chip_select_low      = csn_ff;
  assign LINK.sck      = sck_ff;
  assign LINK.mosi     = mosi_ff;
endmodule // sfpp_host

/* File: verification/sfpp_link_monitor.sv */
/* Pin relations between programmer end and device end.
   Assumes one core clock and a synchronous reset for both ends. */
`timescale 1ns/1ns
module sfpp_link_monitor (
  // Clock, reset and link pins
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic program_mode_pin,
  input wire logic sck,
  input wire logic chip_select_low,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Link pin timing
  sel_program_mode_pin_a: assert property (!chip_select_low |-> program_mode_pin) else $error("select without program_mode_pin");
  settle_gap_a: assert property ($rose(program_mode_pin) |-> chip_select_low [*8]) else $error("early select");
  slave_off_a: assert property (!program_mode_pin [*4] |-> !miso_oe) else $error("miso driven");
  sck_idle_a: assert property (chip_select_low |-> !sck) else $error("sck while idle");
  sck_high_a: assert property ($rose(sck) |-> sck [*8] ##1 !sck) else $error("sck high time");
  sck_low_a: assert property ($fell(sck) |-> !sck [*8]) else $error("sck low time");
  mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi)) else $error("mosi moved");
  miso_hold_a: assert property (sck && $past(sck) && miso_oe |-> $stable(miso)) else $error("miso moved");
  // Traffic seen
  frame_c: cover property ($fell(chip_select_low));
  reply_c: cover property ($rose(miso_oe));
  byte_c: cover property ($rose(sck));
endmodule // sfpp_link_monitor

/* File: verification/sfpp_tb.sv */
/* Bench: both ends joined by one link, programmer end driven over AXI4-Lite.
   Assumes shortened settle and erase counts. */
`timescale 1ns/1ns
module sfpp_tb;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [3:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdt, d;
  logic [1:0] rr;
  logic awr, wrd, bv, arr, rv, ssel, dbg;
  logic [39:0] r;
  int err_count = 0, checked = 0, cyc = 0;
  sfpp_link_if lk ();
  always #25 clk = ~clk;
  // Both ends and the pin monitor
  sfpp_host #(.SETUP_CYCLES(20)) sfpp_host_inst (.CORE_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .LINK(lk.host));
  sfpp_dev #(.ERASE_CYCLES(600)) sfpp_dev_inst (.CORE_CLK(clk), .SYS_RST(rst), .LINK(lk.dev),
    .PROTECT_CONFIG(8'h5a), .SPI_SLAVE_SEL(ssel), .FLASH_BUSY(), .DEBUGGER_EN(dbg));
  sfpp_link_monitor sfpp_link_monitor_inst (.CORE_CLK(clk), .SYS_RST(rst), .program_mode_pin(lk.program_mode_pin), .sck(lk.sck),
    .chip_select_low(lk.chip_select_low), .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe));
  task ck(input logic [39:0] g, e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Register write, both channels held until taken
  task wrg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    {awa, wd, awv, wv, bry} <= {a, v, 3'h7};
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    bry <= 0;
  endtask
  task rdg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    v = rdt;
    rry <= 0;
  endtask
  // One framed command of five bytes, replies gathered
  task fr(input logic [39:0] tx, output logic [39:0] rx);
    wrg(0, 3);
    for (int i = 4; i >= 0; i--) begin
      wrg(4, {24'h0, tx[i*8 +: 8]});
      do rdg(8, d); while (d[0]);
      rdg(4, d);
      rx = {rx[31:0], d[7:0]};
    end
    wrg(0, 1);
    repeat (10) @(posedge clk);
  endtask
  task fc(input logic [39:0] tx, input logic [15:0] e);
    fr(tx, r);
    ck(r[15:0], e);
  endtask
  task test_done;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      err_count++;
      test_done;
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    wrg(0, 1);
    do rdg(8, d); while (!d[1]);
    ck({ssel, dbg}, 2'b10);
    fc(40'h0500000000, 0);
    fr(40'h0600000000, r);
    fc(40'h0500000000, 16'h2020);
    fr(40'hab00000000, r);
    fc(40'h0500000000, 16'h2020);
    fr(40'h0400000000, r);
    fc(40'h0500000000, 0);
    fr(40'h01ff000000, r);
    fc(40'h0500000000, 16'h2828);
    fr(40'h0100000000, r);
    $display("status test done");
    fr(40'h0600000000, r);
    fr(40'h027fffa53c, r);
    do fr(40'h0500000000, r); while (r[4]);
    fc(40'h037fff0000, 16'ha53c);
    fr(40'h0600000000, r);
    fr(40'h523f000000, r);
    do fr(40'h0500000000, r); while (r[4]);
    fc(40'h037fff0000, 16'hff3c);
    fr(40'h8900000000, r);
    ck(r[31:24], 8'h5a);
    $display("flash test done");
    fr(40'h0600000000, r);
    fr(40'h8500000000, r);
    do fr(40'h0500000000, r); while (r[4]);
    fc(40'h0300000000, 0);
    fr(40'h0108000000, r);
    fc(40'h0300220000, 16'hff00);
    fr(40'h0600000000, r);
    fr(40'h6200000000, r);
    do fr(40'h0500000000, r); while (r[4]);
    fc(40'h0500000000, 16'h0808);
    rdg(4'hc, d);
    ck({rr, d}, {2'h2, 32'h0});
    $display("lock test done");
    fr(40'h0600000000, r);
    fr(40'h5200000000, r);
    do fr(40'h0500000000, r); while (r[4]);
    fr(40'h0600000000, r);
    fr(40'h8400000000, r);
    do fr(40'h0500000000, r); while (r[4]);
    fc(40'h0300220000, 0);
    fr(40'h0600000000, r);
    fr(40'h8600000000, r);
    do fr(40'h0500000000, r); while (r[4]);
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    wrg(0, 1);
    do rdg(8, d); while (!d[1]);
    ck({ssel, dbg}, 2'b11);
    fc(40'h0500000000, 16'h8282);
    $display("debug test done");
    test_done;
  end
endmodule // sfpp_tb
